// ==== sscb_top.sv ====
// status set/clear bank: internal status word behind set and clear views
// assumes a same-clock register master and error conditions arriving from the bus clock domain
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "sscb_regs.svh"

module sscb_top (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST_N,
	// register port
	input  wire logic [`SSCB_ADDR_W-1:0] ADDR,
	input  wire logic [31:0]             WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [31:0]             RDATA,
	// level conditions from the bus clock domain
	input  wire logic                    PARITY_ERROR_COND,
	input  wire logic                    SYSTEM_ERROR_COND,
	input  wire logic                    MASTER_ABORT_COND,
	input  wire logic                    TARGET_ABORT_COND,
	// power state, high in full power
	input  wire logic                    POWER_D0,
	// open-drain host interrupt pin
	input  wire logic                    HOST_IRQ_N_SENSE,
	output logic                         HOST_IRQ_N_LEVEL,
	output logic                         HOST_IRQ_N_OE_N,
	// local interrupt
	output logic                         IRQ
);

	logic [1:0]              rst_pipe_reg;
	logic                    rst_n;
	logic [3:0]              cond_sync;
	logic [1:0]              pin_sync;
	logic [31:0]             cond_word;
	logic [31:0]             wr_bits;
	sscb_pkg::sscb_state_t   st_reg;
	sscb_pkg::sscb_state_t   st_next;
	sscb_pkg::sscb_sel_t     rsel;
	sscb_pkg::sscb_sel_t     wsel;

	// address decode shared by reads and writes
	function automatic sscb_pkg::sscb_sel_t decode(input logic [`SSCB_ADDR_W-1:0] a);
		case (a)
			`SSCB_OFS_STAT_SET: decode = sscb_pkg::SSCB_SEL_STAT_SET;
			`SSCB_OFS_STAT_CLR: decode = sscb_pkg::SSCB_SEL_STAT_CLR;
			`SSCB_OFS_HEN_SET:  decode = sscb_pkg::SSCB_SEL_HEN_SET;
			`SSCB_OFS_HEN_CLR:  decode = sscb_pkg::SSCB_SEL_HEN_CLR;
			`SSCB_OFS_EVT:      decode = sscb_pkg::SSCB_SEL_EVT;
			`SSCB_OFS_EVT_MASK: decode = sscb_pkg::SSCB_SEL_EVT_MASK;
			`SSCB_OFS_PINS:     decode = sscb_pkg::SSCB_SEL_PINS;
			default:            decode = sscb_pkg::SSCB_SEL_NONE;
		endcase
	endfunction

	// place the four synchronised conditions on their status positions
	function automatic logic [31:0] place_conds(input logic [3:0] c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SSCB_PERR_BIT]   = c[3];
		w[`SSCB_SERR_BIT]   = c[2];
		w[`SSCB_MABORT_BIT] = c[1];
		w[`SSCB_TABORT_BIT] = c[0];
		return w;
	endfunction

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe_reg[1];

	// conditions cross from the bus clock over three stages
	sscb_sync #(
		.WIDTH  (4),
		.STAGES (`SSCB_SYNC_STAGES)
	) u_cond_sync (
		.clk   (CLK),
		.rst_n (rst_n),
		.d     ({PARITY_ERROR_COND, SYSTEM_ERROR_COND, MASTER_ABORT_COND, TARGET_ABORT_COND}),
		.q     (cond_sync)
	);

	// power state and pin readback are plain pin levels
	sscb_sync #(
		.WIDTH  (2),
		.STAGES (`SSCB_PIN_STAGES)
	) u_pin_sync (
		.clk   (CLK),
		.rst_n (rst_n),
		.d     ({POWER_D0, HOST_IRQ_N_SENSE}),
		.q     (pin_sync)
	);

	assign cond_word = place_conds(cond_sync);
	assign rsel      = RD ? decode(ADDR) : sscb_pkg::SSCB_SEL_NONE;
	assign wsel      = WR ? decode(ADDR) : sscb_pkg::SSCB_SEL_NONE;
	assign wr_bits   = WDATA & `SSCB_DEFINED_MASK; // reserved write bits dropped

	// next state: views, host enable, events, read data and pin drive
	always_comb begin
		st_next = st_reg;

		// register writes change the status word only through the two views
		case (wsel)
			sscb_pkg::SSCB_SEL_STAT_SET: begin
				st_next.status = st_reg.status | wr_bits;
			end
			sscb_pkg::SSCB_SEL_STAT_CLR: begin
				st_next.status = st_reg.status & ~(wr_bits & ~cond_word);
			end
			sscb_pkg::SSCB_SEL_HEN_SET: begin
				st_next.host_en = st_reg.host_en | wr_bits;
			end
			sscb_pkg::SSCB_SEL_HEN_CLR: begin
				st_next.host_en = st_reg.host_en & ~wr_bits;
			end
			sscb_pkg::SSCB_SEL_EVT: begin
				st_next.evt = st_reg.evt & ~wr_bits;
			end
			sscb_pkg::SSCB_SEL_EVT_MASK: begin
				st_next.evt_mask = wr_bits;
			end
			default: begin
				st_next.status = st_reg.status;
			end
		endcase

		// a live condition always wins over a clear in the same cycle
		st_next.status = st_next.status | cond_word;

		// newly raised status bits latch as events; the set wins over a one-to-clear
		st_next.evt = st_next.evt | (st_next.status & ~st_reg.status);
		st_next.irq = |(st_next.evt & st_next.evt_mask);

		// full-power gate; in low-power states the pin is released
		st_next.host_drive = pin_sync[1] && |(st_reg.status & st_reg.host_en);

		// read data for one cycle only, zero for unmapped addresses
		case (rsel)
			sscb_pkg::SSCB_SEL_STAT_SET,
			sscb_pkg::SSCB_SEL_STAT_CLR: begin
				st_next.rdata = st_reg.status;
			end
			sscb_pkg::SSCB_SEL_HEN_SET: begin
				st_next.rdata = st_reg.host_en;
			end
			sscb_pkg::SSCB_SEL_HEN_CLR: begin
				st_next.rdata = st_reg.status & st_reg.host_en;
			end
			sscb_pkg::SSCB_SEL_EVT: begin
				st_next.rdata = st_reg.evt;
			end
			sscb_pkg::SSCB_SEL_EVT_MASK: begin
				st_next.rdata = st_reg.evt_mask;
			end
			sscb_pkg::SSCB_SEL_PINS: begin
				st_next.rdata = {30'h0, pin_sync};
			end
			default: begin
				st_next.rdata = 32'h0000_0000;
			end
		endcase
	end

	// single state register; everything clears on reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.status     <= `SSCB_STAT_RESET;
			st_reg.host_en    <= 32'h0000_0000;
			st_reg.evt        <= 32'h0000_0000;
			st_reg.evt_mask   <= 32'h0000_0000;
			st_reg.rdata      <= 32'h0000_0000;
			st_reg.irq        <= 1'b0;
			st_reg.host_drive <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs; the pin only ever pulls low, so the output level is a constant zero
	assign RDATA            = st_reg.rdata;
	assign IRQ              = st_reg.irq;
	assign HOST_IRQ_N_LEVEL = 1'b0;
	assign HOST_IRQ_N_OE_N  = ~st_reg.host_drive;

	// helper: raw condition word on its status positions, before synchronisation
	logic [31:0] raw_cond_word;
	assign raw_cond_word = place_conds({PARITY_ERROR_COND, SYSTEM_ERROR_COND,
		MASTER_ABORT_COND, TARGET_ABORT_COND});

	// read of either view returns the status of the read cycle
	property p_read_views;
		@(posedge CLK) disable iff (!rst_n)
		(RD && (ADDR == `SSCB_OFS_STAT_SET || ADDR == `SSCB_OFS_STAT_CLR))
			|=> (RDATA == $past(st_reg.status));
	endproperty
	a_read_views: assert property (p_read_views)
		else $error("status view read data wrong");

	// ones written to the set view are present next cycle
	property p_set_view;
		@(posedge CLK) disable iff (!rst_n)
		(WR && ADDR == `SSCB_OFS_STAT_SET)
			|=> ((st_reg.status & $past(wr_bits)) == $past(wr_bits));
	endproperty
	a_set_view: assert property (p_set_view)
		else $error("set view write did not set bits");

	// a clear write cannot remove a bit whose condition is still live
	property p_clear_blocked;
		@(posedge CLK) disable iff (!rst_n)
		(WR && ADDR == `SSCB_OFS_STAT_CLR && (wr_bits & cond_word) != 32'h0000_0000)
			|=> ((st_reg.status & $past(wr_bits & cond_word)) == $past(wr_bits & cond_word));
	endproperty
	a_clear_blocked: assert property (p_clear_blocked)
		else $error("status bit cleared while condition live");

	// synchronised copy trails the raw condition by exactly three clocks
	property p_sync_delay;
		@(posedge CLK) disable iff (!rst_n)
		$past(rst_n, 4) |-> (cond_word == $past(raw_cond_word, 3));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("condition sync delay is not three clocks");

	// software flags appear only through the set view, at their own positions
	property p_soft_flags;
		@(posedge CLK) disable iff (!rst_n)
		(WR && ADDR == `SSCB_OFS_STAT_SET && WDATA[`SSCB_SOFT_MSB:`SSCB_SOFT_LSB] == 4'hF)
			|=> (st_reg.status[`SSCB_SOFT_MSB:`SSCB_SOFT_LSB] == 4'hF);
	endproperty
	a_soft_flags: assert property (p_soft_flags)
		else $error("software flags not set");

	// master abort sits at its documented position and sets by write
	property p_mabort_bit;
		@(posedge CLK) disable iff (!rst_n)
		(WR && ADDR == `SSCB_OFS_STAT_SET && WDATA[`SSCB_MABORT_BIT])
			|=> st_reg.status[`SSCB_MABORT_BIT] ##1 RDATA[`SSCB_MABORT_BIT] || !$past(RD);
	endproperty
	a_mabort_bit: assert property (p_mabort_bit)
		else $error("master abort flag not set by write");

	// reserved positions never hold a one and never read back as one
	property p_reserved_zero;
		@(posedge CLK) disable iff (!rst_n)
		((st_reg.status & ~`SSCB_DEFINED_MASK) == 32'h0000_0000)
			&& ((st_reg.evt & ~`SSCB_DEFINED_MASK) == 32'h0000_0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved status bit set");

	// first cycle out of reset shows an empty status word and a released pin
	property p_reset_clear;
		@(posedge CLK)
		$rose(rst_n) |-> (st_reg.status == 32'h0000_0000) && HOST_IRQ_N_OE_N && !IRQ;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("status not clear after reset");

	// host pin follows status and enable overlap in full power, one clock later
	property p_host_pin;
		@(posedge CLK) disable iff (!rst_n)
		$past(rst_n) |-> (HOST_IRQ_N_OE_N ==
			!($past(pin_sync[1]) && |$past(st_reg.status & st_reg.host_en)));
	endproperty
	a_host_pin: assert property (p_host_pin)
		else $error("host interrupt pin level wrong");

	// clear request on a bit with no live condition, then the bit is gone
	sequence s_clear_free;
		WR && ADDR == `SSCB_OFS_STAT_CLR && (wr_bits & ~cond_word) != 32'h0000_0000;
	endsequence
	sequence s_bit_gone(logic [31:0] bits);
		(st_reg.status & bits) == 32'h0000_0000;
	endsequence
	property p_clear_next;
		@(posedge CLK) disable iff (!rst_n)
		s_clear_free ##0 (cond_word == place_conds(u_cond_sync.chain_reg[1]))
			|=> s_bit_gone($past(wr_bits & ~cond_word));
	endproperty
	a_clear_next: assert property (p_clear_next)
		else $error("clear write did not act on next clock");

	// a set-view write that raises an unmasked status bit brings the local interrupt next clock
	property p_local_irq;
		@(posedge CLK) disable iff (!rst_n)
		(WR && ADDR == `SSCB_OFS_STAT_SET
			&& (wr_bits & ~st_reg.status & st_reg.evt_mask) != 32'h0000_0000) |=> IRQ;
	endproperty
	a_local_irq: assert property (p_local_irq)
		else $error("local interrupt level wrong");

endmodule

`default_nettype wire

// ==== sscb_regs.svh ====
// register offsets, field positions, reset values and timing counts of the status set/clear bank
// assumes a 12-bit word-aligned register port and a 100 MHz peripheral clock
`ifndef SSCB_REGS_SVH
`define SSCB_REGS_SVH

`define SSCB_ADDR_W          12
`define SSCB_OFS_STAT_SET    12'h010
`define SSCB_OFS_STAT_CLR    12'h014
`define SSCB_OFS_HEN_SET     12'h020
`define SSCB_OFS_HEN_CLR     12'h024
`define SSCB_OFS_EVT         12'h040
`define SSCB_OFS_EVT_MASK    12'h044
`define SSCB_OFS_PINS        12'h048

`define SSCB_SOFT_LSB        24
`define SSCB_SOFT_MSB        27
`define SSCB_PERR_BIT        6
`define SSCB_SERR_BIT        5
`define SSCB_MABORT_BIT      2
`define SSCB_TABORT_BIT      1
`define SSCB_DEFINED_MASK    32'h0F00_0066
`define SSCB_STAT_RESET      32'h0000_0000

`define SSCB_SYNC_NS         30
`define SSCB_CLK_NS          10
`define SSCB_SYNC_STAGES     (`SSCB_SYNC_NS / `SSCB_CLK_NS)
`define SSCB_PIN_STAGES      2

`endif

// ==== sscb_pkg.sv ====
// types shared by the status set/clear bank
// assumes sscb_regs.svh supplies the numeric constants
`default_nettype none

package sscb_pkg;

	// one-hot register select from address decode
	typedef enum logic [7:0] {
		SSCB_SEL_NONE     = 8'h01,
		SSCB_SEL_STAT_SET = 8'h02,
		SSCB_SEL_STAT_CLR = 8'h04,
		SSCB_SEL_HEN_SET  = 8'h08,
		SSCB_SEL_HEN_CLR  = 8'h10,
		SSCB_SEL_EVT      = 8'h20,
		SSCB_SEL_EVT_MASK = 8'h40,
		SSCB_SEL_PINS     = 8'h80
	} sscb_sel_t;

	// whole state of the bank
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] host_en;
		logic [31:0] evt;
		logic [31:0] evt_mask;
		logic [31:0] rdata;
		logic        irq;
		logic        host_drive;
	} sscb_state_t;

endpackage

`default_nettype wire

// ==== sscb_sync.sv ====
// multi-stage level synchroniser into the peripheral clock domain
// assumes rst_n is already released synchronously to clk
`timescale 1ns/100ps
`default_nettype none

module sscb_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// levels in and out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [STAGES-1:0][WIDTH-1:0] chain_reg;

	// plain shift chain; stage 0 feeds only stage 1, nothing else looks at it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= {chain_reg[STAGES-2:0], d};
		end
	end

	assign q = chain_reg[STAGES-1];

endmodule

`default_nettype wire

// ==== tb.sv ====
// testbench for the status set/clear bank: register accesses with expected values
// assumes sscb_top with its register port, a pulled-up open-drain host pin and one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "sscb_regs.svh"

module tb;
	logic        clk, rst_n, wr, rd, d0, irq, oe_n, pin_o;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, acc;
	logic [3:0]  cond;
	logic        host_pin;
	int          fails, num_checks, i;
	int          cbit [4] = '{6, 5, 2, 1};

	// pull-up on the open-drain host line
	assign host_pin = oe_n ? 1'b1 : pin_o;

	sscb_top dut (
		.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.PARITY_ERROR_COND(cond[0]), .SYSTEM_ERROR_COND(cond[1]),
		.MASTER_ABORT_COND(cond[2]), .TARGET_ABORT_COND(cond[3]),
		.POWER_D0(d0), .HOST_IRQ_N_SENSE(host_pin), .HOST_IRQ_N_LEVEL(pin_o),
		.HOST_IRQ_N_OE_N(oe_n), .IRQ(irq)
	);

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// tasks are entered right after a rising edge; a write keeps its strobe for the next write
	task wrt(input logic [11:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		rd    <= 1'b0;
		@(posedge clk);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
		addr <= a;
		rd   <= 1'b1;
		wr   <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(name, exp, rdata);
		@(posedge clk);
	endtask

	task idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// level outputs are looked at mid-cycle, away from the updating edge
	task pins(input int n, input logic e_irq, input logic e_oen);
		idle(n);
		@(negedge clk);
		check("irq", {31'h0, e_irq}, {31'h0, irq});
		check("host_oe_n", {31'h0, e_oen}, {31'h0, oe_n});
		check("host_o", 32'h0, {31'h0, pin_o});
		@(posedge clk);
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 12'h000; wdata = 32'h0; cond = 4'h0; d0 = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		idle(4);
		// reset values of both status views, host enable and events, pins readback and an unmapped hole
		rdc(`SSCB_OFS_STAT_SET, 32'h0, "set_view");
		rdc(`SSCB_OFS_STAT_CLR, 32'h0, "clr_view");
		rdc(`SSCB_OFS_HEN_SET, 32'h0, "hen");
		rdc(`SSCB_OFS_EVT, 32'h0, "evt");
		rdc(`SSCB_OFS_PINS, 32'h3, "pins");
		wrt(12'h0FC, 32'h0F000066);
		rdc(12'h0FC, 32'h0, "unmapped");
		rdc(`SSCB_OFS_STAT_SET, 32'h0, "set_view");
		$display("test reset done");

		// zeros and reserved bits leave the word alone, then each field set in turn
		wrt(`SSCB_OFS_STAT_SET, 32'h0);
		wrt(`SSCB_OFS_STAT_SET, 32'h70FFFF99);
		rdc(`SSCB_OFS_STAT_SET, 32'h0, "reserved");
		acc = 32'h0;
		for (i = 0; i < 32; i++) begin
			if (`SSCB_DEFINED_MASK & (32'h1 << i)) begin
				acc = acc | (32'h1 << i);
				wrt(`SSCB_OFS_STAT_SET, 32'h1 << i);
				rdc(`SSCB_OFS_STAT_SET, acc, "set_view");
				rdc(`SSCB_OFS_STAT_CLR, acc, "clr_view");
			end
		end
		wrt(`SSCB_OFS_STAT_CLR, 32'h0);
		rdc(`SSCB_OFS_STAT_CLR, acc, "clr_zero");
		wrt(`SSCB_OFS_STAT_CLR, 32'h7FFFFFFF);
		rdc(`SSCB_OFS_STAT_SET, 32'h0, "cleared");
		$display("test set and clear views done");

		// a live condition defeats clears until its synced copy has gone
		for (i = 0; i < 4; i++) begin
			cond <= 4'h1 << i;
			idle(6);
			rdc(`SSCB_OFS_STAT_SET, 32'h1 << cbit[i], "cond_set");
			wrt(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i]);
			rdc(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i], "cond_held");
			// clears in the three clocks after removal must still bounce; a shorter sync would let one land
			cond <= 4'h0;
			wrt(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i]);
			wrt(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i]);
			wrt(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i]);
			rdc(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i], "sync_delay");
			wrt(`SSCB_OFS_STAT_CLR, 32'h1 << cbit[i]);
			rdc(`SSCB_OFS_STAT_CLR, 32'h0, "cond_gone");
		end
		$display("test conditions done");

		// local interrupt: raise, mask, unmask, clear
		wrt(`SSCB_OFS_EVT, 32'h0F000066);
		wrt(`SSCB_OFS_EVT_MASK, 32'h0F000066);
		rdc(`SSCB_OFS_EVT_MASK, 32'h0F000066, "mask");
		rdc(`SSCB_OFS_EVT, 32'h0, "evt_clr");
		pins(2, 1'b0, 1'b1);
		wrt(`SSCB_OFS_STAT_SET, 32'h01000000);
		rdc(`SSCB_OFS_EVT, 32'h01000000, "evt");
		pins(2, 1'b1, 1'b1);
		wrt(`SSCB_OFS_EVT_MASK, 32'h0);
		pins(2, 1'b0, 1'b1);
		wrt(`SSCB_OFS_EVT_MASK, 32'h01000000);
		pins(2, 1'b1, 1'b1);
		wrt(`SSCB_OFS_EVT, 32'h01000000);
		pins(2, 1'b0, 1'b1);
		rdc(`SSCB_OFS_STAT_SET, 32'h01000000, "status_kept");
		$display("test local interrupt done");

		// host line follows status and enable only in full power
		wrt(`SSCB_OFS_HEN_SET, 32'h01000000);
		rdc(`SSCB_OFS_HEN_SET, 32'h01000000, "hen");
		pins(2, 1'b0, 1'b0);
		rdc(`SSCB_OFS_HEN_CLR, 32'h01000000, "masked_status");
		idle(3);
		rdc(`SSCB_OFS_PINS, 32'h2, "pins_low");
		d0 <= 1'b0;
		pins(5, 1'b0, 1'b1);
		rdc(`SSCB_OFS_PINS, 32'h1, "pins_sleep");
		d0 <= 1'b1;
		pins(5, 1'b0, 1'b0);
		wrt(`SSCB_OFS_STAT_CLR, 32'h01000000);
		pins(2, 1'b0, 1'b1);
		wrt(`SSCB_OFS_HEN_CLR, 32'h01000000);
		rdc(`SSCB_OFS_HEN_SET, 32'h0, "hen_clr");
		$display("test host interrupt done");

		// second reset in mid-run wipes set bits
		wrt(`SSCB_OFS_STAT_SET, 32'h0F000066);
		idle(1);
		rst_n <= 1'b0;
		idle(3);
		rst_n <= 1'b1;
		idle(4);
		rdc(`SSCB_OFS_STAT_SET, 32'h0, "after_reset");
		$display("test second reset done");
		print_verdict();
	end
endmodule

`default_nettype wire
